// ==== lpirq_top.v ====
`timescale 1ns/1ps
`include "lpirq_defs.vh"

module lpirq_top (
  // Clock and bus reset
  input wire I_CLK,
  input wire I_RST,
  // Power-on suspend (S1) state
  input wire I_SUSPEND,
  // Configuration access
  input wire I_CFG_WE,
  input wire I_CFG_RE,
  input wire [7:0] I_CFG_ADDR,
  input wire [7:0] I_CFG_WDATA,
  output reg [7:0] O_CFG_RDATA,
  // I/O cycle request from the bridge
  input wire I_IO_REQ,
  input wire I_IO_WRITE,
  input wire [15:0] I_IO_ADDR,
  input wire [7:0] I_IO_WDATA,
  output wire O_IO_ACK,
  output reg O_IO_DONE,
  output reg [7:0] O_IO_RDATA,
  // Peripheral side bus
  output reg [15:0] O_PERIPH_ADDR,
  output reg O_IO_READ_STROBE_N,
  output reg O_IO_READ_STROBE_OE_N,
  output reg O_IO_WRITE_STROBE_N,
  output reg O_IO_WRITE_STROBE_OE_N,
  input wire [7:0] I_PERIPHERAL_DATA_LINES,
  output reg [7:0] O_PERIPHERAL_DATA_LINES,
  output reg O_PERIPHERAL_DATA_LINES_OE_N,
  output reg O_KEYBOARD_CTRL_SELECT_N,
  // Interrupt inputs
  input wire I_KEYBOARD_INTERRUPT_INPUT,
  input wire [7:3] I_IRQ_LINES,
  input wire I_ALARM_INTERRUPT_INPUT_N,
  input wire I_POINTER_INTERRUPT_INPUT,
  // Requests to the interrupt controller
  output reg [15:0] O_IRQ_REQ
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SETUP = 5'h02;
  localparam [4:0] ST_STROBE = 5'h04;
  localparam [4:0] ST_RECOVER = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;

  localparam [31:0] SETUP_SPAN = `LPIRQ_SETUP_CYC - 1;
  localparam [31:0] STROBE_SPAN = `LPIRQ_STROBE_CYC - 1;
  localparam [31:0] RECOVER_SPAN = `LPIRQ_RECOVER_CYC - 1;
  localparam [`LPIRQ_CNT_W-1:0] SETUP_LAST = SETUP_SPAN[`LPIRQ_CNT_W-1:0];
  localparam [`LPIRQ_CNT_W-1:0] STROBE_LAST = STROBE_SPAN[`LPIRQ_CNT_W-1:0];
  localparam [`LPIRQ_CNT_W-1:0] RECOVER_LAST = RECOVER_SPAN[`LPIRQ_CNT_W-1:0];

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [7:0] chip_select_cfg;
  reg [7:0] edge_level_control1;
  reg [7:0] edge_level_control2;
  reg [4:0] state;
  reg [4:0] next_state;
  reg [`LPIRQ_CNT_W-1:0] cnt;
  reg [`LPIRQ_CNT_W-1:0] next_cnt;
  reg cyc_write;
  reg [7:0] cyc_wdata;
  reg out_enabled;
  wire mouse_mode;
  wire start;
  wire kbc_hit;
  wire port60_hit;
  wire strobe_fall;
  reg port60_read_clr;
  wire [7:3] irq_sync;
  wire kbd_sync;
  wire ptr_sync;
  wire alarm_sync;
  reg [7:3] irq_prev;
  reg ptr_prev;
  reg alarm_prev;
  wire kbd_flag;
  wire mouse_flag;
  wire [7:3] line_req;
  wire ptr_std_req;
  wire alarm_req;

  assign mouse_mode = chip_select_cfg[`LPIRQ_CS_MOUSE_BIT];

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      chip_select_cfg <= `LPIRQ_CFG_CS_RST;
      edge_level_control1 <= `LPIRQ_CFG_ELC_RST;
      edge_level_control2 <= `LPIRQ_CFG_ELC_RST;
    end else if (I_CFG_WE) begin
      case (I_CFG_ADDR)
        `LPIRQ_CFG_CS_OFS: begin
          chip_select_cfg <= I_CFG_WDATA;
        end
        `LPIRQ_CFG_ELC1_OFS: begin
          edge_level_control1 <= I_CFG_WDATA;
        end
        `LPIRQ_CFG_ELC2_OFS: begin
          edge_level_control2 <= I_CFG_WDATA;
        end
        default: begin
          chip_select_cfg <= chip_select_cfg;
        end
      endcase
    end
  end

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CFG_RDATA <= 8'h00;
    end else if (I_CFG_RE) begin
      case (I_CFG_ADDR)
        `LPIRQ_CFG_CS_OFS: begin
          O_CFG_RDATA <= chip_select_cfg;
        end
        `LPIRQ_CFG_ELC1_OFS: begin
          O_CFG_RDATA <= edge_level_control1;
        end
        `LPIRQ_CFG_ELC2_OFS: begin
          O_CFG_RDATA <= edge_level_control2;
        end
        default: begin
          O_CFG_RDATA <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // I/O cycle sequencer
  // ****************************************************************
  // No new cycle starts while the system sits in power-on suspend
  assign start = (state == ST_IDLE) & I_IO_REQ & ~I_SUSPEND & out_enabled;
  assign O_IO_ACK = start;

  always @* begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_IDLE: begin
        next_cnt = {`LPIRQ_CNT_W{1'b0}};
        if (start) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt == SETUP_LAST) begin
          next_cnt = {`LPIRQ_CNT_W{1'b0}};
          next_state = ST_STROBE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_STROBE: begin
        if (cnt == STROBE_LAST) begin
          next_cnt = {`LPIRQ_CNT_W{1'b0}};
          next_state = ST_RECOVER;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_RECOVER: begin
        if (cnt == RECOVER_LAST) begin
          next_cnt = {`LPIRQ_CNT_W{1'b0}};
          next_state = ST_DONE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_cnt = {`LPIRQ_CNT_W{1'b0}};
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_IDLE;
      cnt <= {`LPIRQ_CNT_W{1'b0}};
      cyc_write <= 1'b0;
      cyc_wdata <= 8'h00;
      O_PERIPH_ADDR <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (start) begin
        cyc_write <= I_IO_WRITE;
        cyc_wdata <= I_IO_WDATA;
        O_PERIPH_ADDR <= I_IO_ADDR;
      end
    end
  end

  // ****************************************************************
  // Strobes, data lines and keyboard select
  // ****************************************************************
  assign kbc_hit = (O_PERIPH_ADDR == `LPIRQ_KBC_DATA_PORT) | (O_PERIPH_ADDR == `LPIRQ_KBC_CMD_PORT);
  assign port60_hit = (O_PERIPH_ADDR == `LPIRQ_KBC_DATA_PORT) & ~cyc_write;
  // The read strobe falls on the first cycle of the strobe phase
  assign strobe_fall = (state == ST_SETUP) & (next_state == ST_STROBE);

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      out_enabled <= 1'b0;
      O_IO_READ_STROBE_OE_N <= 1'b1;
      O_IO_WRITE_STROBE_OE_N <= 1'b1;
      O_IO_READ_STROBE_N <= 1'b1;
      O_IO_WRITE_STROBE_N <= 1'b1;
      O_PERIPHERAL_DATA_LINES <= 8'h00;
      O_PERIPHERAL_DATA_LINES_OE_N <= 1'b1;
      O_KEYBOARD_CTRL_SELECT_N <= 1'b1;
      O_IO_DONE <= 1'b0;
      O_IO_RDATA <= 8'h00;
      port60_read_clr <= 1'b0;
    end else begin
      out_enabled <= 1'b1;
      O_IO_READ_STROBE_OE_N <= 1'b0;
      O_IO_WRITE_STROBE_OE_N <= 1'b0;
      if (strobe_fall && !cyc_write) begin
        O_IO_READ_STROBE_N <= 1'b0;
      end else if (next_state != ST_STROBE) begin
        O_IO_READ_STROBE_N <= 1'b1;
      end
      if (strobe_fall && cyc_write) begin
        O_IO_WRITE_STROBE_N <= 1'b0;
      end else if (next_state != ST_STROBE) begin
        O_IO_WRITE_STROBE_N <= 1'b1;
      end
      // Write data is driven from setup until recovery ends
      if (start && I_IO_WRITE) begin
        O_PERIPHERAL_DATA_LINES <= I_IO_WDATA;
        O_PERIPHERAL_DATA_LINES_OE_N <= 1'b0;
      end else if (next_state == ST_DONE || next_state == ST_IDLE) begin
        O_PERIPHERAL_DATA_LINES_OE_N <= 1'b1;
      end
      if (next_state == ST_SETUP || next_state == ST_STROBE || next_state == ST_RECOVER) begin
        O_KEYBOARD_CTRL_SELECT_N <= ~((start ? ((I_IO_ADDR == `LPIRQ_KBC_DATA_PORT) |
          (I_IO_ADDR == `LPIRQ_KBC_CMD_PORT)) : kbc_hit));
      end else begin
        O_KEYBOARD_CTRL_SELECT_N <= 1'b1;
      end
      // Read data is sampled in the last strobe cycle, still valid
      if (state == ST_STROBE && cnt == STROBE_LAST && !cyc_write) begin
        O_IO_RDATA <= I_PERIPHERAL_DATA_LINES;
      end
      O_IO_DONE <= (next_state == ST_DONE);
      port60_read_clr <= strobe_fall & port60_hit;
    end
  end

  // ****************************************************************
  // Interrupt input synchronisers
  // ****************************************************************
  // Alarm pin enters inverted so every stage idles low out of reset, no false edge
  lpirq_sync #(
    .W(8)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_async({I_KEYBOARD_INTERRUPT_INPUT, I_IRQ_LINES, ~I_ALARM_INTERRUPT_INPUT_N, I_POINTER_INTERRUPT_INPUT}),
    .o_sync({kbd_sync, irq_sync, alarm_sync, ptr_sync})
  );

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_prev <= 5'h00;
      ptr_prev <= 1'b0;
      alarm_prev <= 1'b0;
    end else begin
      irq_prev <= irq_sync;
      ptr_prev <= ptr_sync;
      alarm_prev <= alarm_sync;
    end
  end

  // ****************************************************************
  // Lines 3 to 7: edge or level per line
  // ****************************************************************
  genvar g;
  generate
    for (g = `LPIRQ_IRQ_FIRST; g <= `LPIRQ_IRQ_LAST; g = g + 1) begin : g_line
      assign line_req[g] = edge_level_control1[g] ? irq_sync[g] :
        (irq_sync[g] & ~irq_prev[g]);
    end
  endgenerate

  // Alarm is a fixed falling-edge request, no control bit applies
  assign alarm_req = alarm_sync & ~alarm_prev;
  assign ptr_std_req = edge_level_control2[`LPIRQ_ELC2_PTR_BIT] ? ptr_sync : (ptr_sync & ~ptr_prev);

  // ****************************************************************
  // Keyboard and mouse latches
  // ****************************************************************
  lpirq_latch u_kbd_latch (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_enable(1'b1),
    .i_level(kbd_sync),
    .i_clear(port60_read_clr),
    .o_flag(kbd_flag)
  );

  lpirq_latch u_mouse_latch (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_enable(mouse_mode),
    .i_level(ptr_sync),
    .i_clear(port60_read_clr),
    .o_flag(mouse_flag)
  );

  // ****************************************************************
  // Requests to the interrupt controller
  // ****************************************************************
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_IRQ_REQ <= 16'h0000;
    end else begin
      O_IRQ_REQ <= 16'h0000;
      O_IRQ_REQ[`LPIRQ_IRQ_KBD] <= kbd_flag;
      O_IRQ_REQ[`LPIRQ_IRQ_LAST:`LPIRQ_IRQ_FIRST] <= line_req;
      O_IRQ_REQ[`LPIRQ_IRQ_ALARM] <= alarm_req;
      O_IRQ_REQ[`LPIRQ_IRQ_PTR] <= mouse_mode ? mouse_flag : ptr_std_req;
    end
  end

endmodule // lpirq_top

// ==== lpirq_defs.vh ====
`ifndef LPIRQ_DEFS_VH
`define LPIRQ_DEFS_VH

// ****************************************************************
// Configuration space offsets
// ****************************************************************
`define LPIRQ_CFG_CS_OFS 8'h4e
`define LPIRQ_CFG_ELC1_OFS 8'h60
`define LPIRQ_CFG_ELC2_OFS 8'h61
`define LPIRQ_CFG_CS_RST 8'h00
`define LPIRQ_CFG_ELC_RST 8'h00
`define LPIRQ_CS_MOUSE_BIT 4

// ****************************************************************
// Peripheral I/O ports
// ****************************************************************
`define LPIRQ_KBC_DATA_PORT 16'h0060
`define LPIRQ_KBC_CMD_PORT 16'h0064

// ****************************************************************
// Interrupt line numbers
// ****************************************************************
`define LPIRQ_IRQ_KBD 1
`define LPIRQ_IRQ_ALARM 8
`define LPIRQ_IRQ_PTR 12
`define LPIRQ_IRQ_FIRST 3
`define LPIRQ_IRQ_LAST 7
`define LPIRQ_ELC2_PTR_BIT 4

// ****************************************************************
// Strobe timing
// ****************************************************************
`define LPIRQ_CLK_NS 25
`define LPIRQ_STROBE_NS 125
`define LPIRQ_SETUP_NS 25
`define LPIRQ_RECOVER_NS 50
`define LPIRQ_STROBE_CYC ((`LPIRQ_STROBE_NS + `LPIRQ_CLK_NS - 1) / `LPIRQ_CLK_NS)
`define LPIRQ_SETUP_CYC ((`LPIRQ_SETUP_NS + `LPIRQ_CLK_NS - 1) / `LPIRQ_CLK_NS)
`define LPIRQ_RECOVER_CYC ((`LPIRQ_RECOVER_NS + `LPIRQ_CLK_NS - 1) / `LPIRQ_CLK_NS)
`define LPIRQ_CNT_W 4

`endif

// ==== lpirq_sync.v ====
`timescale 1ns/1ps
// ****************************************************************
// Two-stage synchroniser, one per bit
// ****************************************************************
module lpirq_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Data
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta;
      reg stable;
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= i_async[g];
          stable <= meta;
        end
      end
      assign o_sync[g] = stable;
    end
  endgenerate
endmodule // lpirq_sync

// ==== lpirq_latch.v ====
`timescale 1ns/1ps
// ****************************************************************
// Rising-edge catch latch, cleared by a pulse; a set beats a clear
// ****************************************************************
module lpirq_latch (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Control
  input wire i_enable,
  input wire i_level,
  input wire i_clear,
  // State
  output reg o_flag
);
  reg prev;
  wire rise;

  assign rise = i_level & ~prev;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev <= 1'b0;
      o_flag <= 1'b0;
    end else begin
      prev <= i_level;
      if (i_enable && rise) begin
        o_flag <= 1'b1;
      end else if (i_clear || !i_enable) begin
        o_flag <= 1'b0;
      end
    end
  end
endmodule // lpirq_latch

// ==== lpirq_top_asserts.sv ====
`timescale 1ns/1ps
module lpirq_top_asserts (
  // Clock and reset
  input wire I_CLK,
  input wire I_RST,
  // Requests
  input wire I_SUSPEND,
  input wire I_IO_REQ,
  input wire I_IO_WRITE,
  input wire [7:0] I_IO_WDATA,
  input wire I_ALARM_INTERRUPT_INPUT_N,
  // Design outputs
  input wire O_IO_ACK,
  input wire O_IO_DONE,
  input wire [15:0] O_PERIPH_ADDR,
  input wire O_IO_READ_STROBE_N,
  input wire O_IO_READ_STROBE_OE_N,
  input wire O_IO_WRITE_STROBE_N,
  input wire O_IO_WRITE_STROBE_OE_N,
  input wire [7:0] O_PERIPHERAL_DATA_LINES,
  input wire O_PERIPHERAL_DATA_LINES_OE_N,
  input wire O_KEYBOARD_CTRL_SELECT_N,
  input wire [15:0] O_IRQ_REQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire take = I_IO_REQ && O_IO_ACK;
  wire kbc = (O_PERIPH_ADDR == 16'h0060) || (O_PERIPH_ADDR == 16'h0064);
  wire rd60 = (O_PERIPH_ADDR == 16'h0060);
  a_rd_rst_high: assert property (
    disable iff (1'b0) I_RST |-> O_IO_READ_STROBE_N && O_IO_READ_STROBE_OE_N)
    else $error("read strobe not released in reset");
  a_wr_rst_high: assert property (
    disable iff (1'b0) I_RST |-> O_IO_WRITE_STROBE_N && O_IO_WRITE_STROBE_OE_N)
    else $error("write strobe not released in reset");
  a_strobe_driven: assert property (
    $past(!I_RST) |-> !O_IO_READ_STROBE_OE_N && !O_IO_WRITE_STROBE_OE_N)
    else $error("strobe not driven after reset");
  a_susp_no_take: assert property (
    I_SUSPEND |-> !O_IO_ACK)
    else $error("cycle accepted in suspend");
  a_rd_width: assert property (
    $fell(O_IO_READ_STROBE_N) |-> !O_IO_READ_STROBE_N [*5] ##1 O_IO_READ_STROBE_N [*2] ##1 O_IO_DONE)
    else $error("read strobe width or done wrong");
  a_rd_start: assert property (
    take && !I_IO_WRITE |-> ##2 $fell(O_IO_READ_STROBE_N))
    else $error("read strobe late");
  a_wr_start: assert property (
    take && I_IO_WRITE |-> ##3 !O_IO_WRITE_STROBE_N && !O_PERIPHERAL_DATA_LINES_OE_N
      && O_PERIPHERAL_DATA_LINES == $past(I_IO_WDATA, 3))
    else $error("write strobe or data wrong");
  a_kbc_select: assert property (
    !O_IO_READ_STROBE_N || !O_IO_WRITE_STROBE_N |-> O_KEYBOARD_CTRL_SELECT_N == !kbc)
    else $error("keyboard select wrong");
  a_alarm_edge: assert property (
    $fell(I_ALARM_INTERRUPT_INPUT_N) |-> ##3 O_IRQ_REQ[8] ##1 !O_IRQ_REQ[8])
    else $error("alarm request pulse wrong");
  a_kbd_hold: assert property (
    O_IRQ_REQ[1] && !(!O_IO_READ_STROBE_N && rd60) |=> O_IRQ_REQ[1])
    else $error("keyboard latch dropped");
endmodule // lpirq_top_asserts
bind lpirq_top lpirq_top_asserts chk_u (.I_CLK, .I_RST, .I_SUSPEND, .I_IO_REQ, .I_IO_WRITE, .I_IO_WDATA,
  .I_ALARM_INTERRUPT_INPUT_N, .O_IO_ACK, .O_IO_DONE, .O_PERIPH_ADDR, .O_IO_READ_STROBE_N,
  .O_IO_READ_STROBE_OE_N, .O_IO_WRITE_STROBE_N, .O_IO_WRITE_STROBE_OE_N, .O_PERIPHERAL_DATA_LINES,
  .O_PERIPHERAL_DATA_LINES_OE_N, .O_KEYBOARD_CTRL_SELECT_N, .O_IRQ_REQ);

// ==== lpirq_periph.sv ====
`timescale 1ns/1ps
module lpirq_periph (
  // Clock
  input wire i_clk,
  // Peripheral side bus
  input wire [15:0] i_addr,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);
  reg [7:0] mem [0:7];
  reg rd_q = 1'b1;
  reg wr_q = 1'b1;
  integer k;
  initial begin
    o_rdata = 8'h00;
    for (k = 0; k < 8; k = k + 1) mem[k] = 8'ha0 + k[7:0];
  end
  always @(posedge i_clk) begin
    rd_q <= i_rd_n;
    wr_q <= i_wr_n;
    // Capture on the trailing edge of the write strobe
    if (i_wr_n && !wr_q)
      mem[i_addr[2:0]] <= i_wdata;
    // Data held one cycle past the strobe, then garbage
    if (!i_rd_n || !rd_q)
      o_rdata <= mem[i_addr[2:0]];
    else
      o_rdata <= ~o_rdata;
  end
endmodule // lpirq_periph

// ==== lpirq_top_test.sv ====
`timescale 1ns/1ps
module lpirq_top_test;
  logic clk = 0, rst = 0, susp = 0, cfg_we = 0, cfg_re = 0, io_req = 0, io_wr = 0;
  logic [7:0] cfg_addr = 0, cfg_wdata = 0, io_wdata = 0, cfg_rdata, io_rdata, dl_out, dl_in, p_rdata, q, n;
  logic [15:0] io_addr = 0, p_addr, irq_req;
  logic io_ack, io_done, rd_n, rd_oe_n, wr_n, wr_oe_n, dl_oe_n, kbc_n;
  logic kbd = 0, alarm_n = 1, ptr = 0;
  logic [7:3] lines = 0;
  int err_count = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  assign dl_in = !dl_oe_n ? dl_out : p_rdata;
  lpirq_top dut_u (.I_CLK(clk), .I_RST(rst), .I_SUSPEND(susp), .I_CFG_WE(cfg_we), .I_CFG_RE(cfg_re),
    .I_CFG_ADDR(cfg_addr), .I_CFG_WDATA(cfg_wdata), .O_CFG_RDATA(cfg_rdata), .I_IO_REQ(io_req),
    .I_IO_WRITE(io_wr), .I_IO_ADDR(io_addr), .I_IO_WDATA(io_wdata), .O_IO_ACK(io_ack), .O_IO_DONE(io_done),
    .O_IO_RDATA(io_rdata), .O_PERIPH_ADDR(p_addr), .O_IO_READ_STROBE_N(rd_n), .O_IO_READ_STROBE_OE_N(rd_oe_n),
    .O_IO_WRITE_STROBE_N(wr_n), .O_IO_WRITE_STROBE_OE_N(wr_oe_n), .I_PERIPHERAL_DATA_LINES(dl_in),
    .O_PERIPHERAL_DATA_LINES(dl_out), .O_PERIPHERAL_DATA_LINES_OE_N(dl_oe_n),
    .O_KEYBOARD_CTRL_SELECT_N(kbc_n), .I_KEYBOARD_INTERRUPT_INPUT(kbd), .I_IRQ_LINES(lines),
    .I_ALARM_INTERRUPT_INPUT_N(alarm_n), .I_POINTER_INTERRUPT_INPUT(ptr), .O_IRQ_REQ(irq_req));
  lpirq_periph periph_u (.i_clk(clk), .i_addr(p_addr), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_wdata(dl_in),
    .o_rdata(p_rdata));
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic tick(input int c);
    repeat (c) begin
      @(posedge clk);
      #2;
    end
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
    cfg_we = w;
    cfg_re = !w;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_we = 0;
    cfg_re = 0;
    q = cfg_rdata;
    tick(1);
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    int c;
    io_req = 1;
    io_wr = w;
    io_addr = a;
    io_wdata = d;
    c = 0;
    #1;
    while (io_ack !== 1'b1 && c < 40) begin
      tick(1);
      c++;
    end
    if (c == 40) err_count++;
    tick(1);
    io_req = 0;
    c = 0;
    while (io_done !== 1'b1 && c < 40) begin
      tick(1);
      c++;
    end
    if (c == 40) err_count++;
    q = io_rdata;
  endtask
  task automatic cnt(input int b);
    n = 0;
    repeat (8) begin
      tick(1);
      if (irq_req[b] === 1'b1) n++;
    end
  endtask
  task close_out;
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #2 rst = 1;
    tick(20);
    chk("reset strobes", 8'h0f, {4'h0, rd_n, rd_oe_n, wr_n, wr_oe_n});
    rst = 0;
    tick(3);
    chk("driven strobes", 8'h0a, {4'h0, rd_n, rd_oe_n, wr_n, wr_oe_n});
    cfg(0, 8'h4e, 0);
    chk("chip select cfg", 8'h00, q);
    cfg(1, 8'h10, 8'hff);
    cfg(0, 8'h10, 0);
    chk("unmapped cfg", 8'h00, q);
    io(1, 16'h0302, 8'h5a);
    io(0, 16'h0302, 0);
    chk("read back", 8'h5a, q);
    io(0, 16'h0305, 0);
    chk("read slave", 8'ha5, q);
    kbd = 1;
    tick(2);
    kbd = 0;
    tick(5);
    chk("kbd latch", 8'h01, {7'h0, irq_req[1]});
    io(0, 16'h0064, 0);
    chk("kbd latch 64h", 8'h01, {7'h0, irq_req[1]});
    io(0, 16'h0060, 0);
    chk("kbd clear", 8'h00, {7'h0, irq_req[1]});
    ptr = 1;
    cnt(12);
    chk("ptr standard", 8'h01, n);
    cfg(1, 8'h61, 8'h10);
    tick(3);
    cnt(12);
    chk("ptr level", 8'h08, n);
    cfg(1, 8'h61, 8'h00);
    ptr = 0;
    cfg(1, 8'h4e, 8'h10);
    cfg(0, 8'h4e, 0);
    chk("mouse mode", 8'h10, q);
    tick(4);
    ptr = 1;
    tick(2);
    ptr = 0;
    tick(20);
    chk("mouse latch", 8'h01, {7'h0, irq_req[12]});
    io(0, 16'h0060, 0);
    chk("mouse clear", 8'h00, {7'h0, irq_req[12]});
    cfg(1, 8'h4e, 8'h00);
    for (int i = 3; i <= 7; i++) begin
      lines[i] = 1'b1;
      cnt(i);
      chk("edge line", 8'h01, n);
      lines[i] = 1'b0;
      cfg(1, 8'h60, 8'h01 << i);
      lines[i] = 1'b1;
      tick(6);
      cnt(i);
      chk("level line", 8'h08, n);
      lines[i] = 1'b0;
      cfg(1, 8'h60, 8'h00);
      tick(6);
    end
    alarm_n = 0;
    cnt(8);
    chk("alarm fall", 8'h01, n);
    alarm_n = 1;
    cnt(8);
    chk("alarm rise", 8'h00, n);
    susp = 1;
    io_req = 1;
    io_wr = 0;
    io_addr = 16'h0303;
    tick(12);
    chk("suspend idle", 8'h01, {6'h0, io_ack, rd_n});
    susp = 0;
    io(0, 16'h0303, 0);
    chk("after suspend", 8'ha3, q);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule // lpirq_top_test
